// File: hdl/link_control_upper_bits.sv
/*
  Upper bits of the general link control register and the packet decisions they steer.
  Assumes an Avalon-MM master on ref_clk_in and link-core strobes on the same clock.
*/
// The Avalon-MM slave port is this design's own decision.
// How it works
// - Accept node packets only while address valid
// - Set address valid after self-ID and refresh
// - Capture merges self-ID packets into queue
// - Capture also queues PHY configuration packets
// - Code 000 follows packet's retry protocol
// - Code 011 forces single phase retry
// - Code 100 follows packet, always busy
// - Code 111 single phase, always busy
// - Transmit only while transmit permit set
`timescale 1ns/100ps
module link_control_upper_bits
  import link_ctl_pkg::*;
(
  input wire logic ref_clk_in, // System clock, 50 MHz.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic [`LCU_ADDR_W-1:0] avs_address_in, // Byte address.
  input wire logic avs_read_in, // Read request.
  input wire logic avs_write_in, // Write request.
  input wire logic [31:0] avs_writedata_in, // Write data.
  input wire logic [3:0] avs_byteenable_in, // Byte lanes.
  output logic [31:0] avs_readdata_out, // Read data.
  output logic avs_waitrequest_out, // Stall while high.
  input wire logic selfid_done_in, // Self-identification completed pulse.
  input wire logic node_id_refresh_in, // Node identifier refreshed pulse.
  input wire logic pkt_strobe_in, // One received packet header pulse.
  input wire logic pkt_to_node_in, // Packet addressed to this node.
  input wire logic pkt_selfid_in, // Packet is a self-ID packet.
  input wire logic pkt_phycfg_in, // Packet is a PHY configuration packet.
  input wire logic pkt_wants_dual_in, // Packet requests dual phase retry.
  input wire logic link_busy_in, // Link cannot take the packet now.
  input wire logic tx_pending_in, // Transmit queue holds a packet.
  output logic decision_valid_out, // Decision outputs are fresh.
  output logic accept_out, // Packet accepted for this node.
  output logic enqueue_out, // Packet written to request queue.
  output logic selfid_start_out, // Enqueued self-ID begins merged packet.
  output logic ack_busy_out, // Busy acknowledge returned.
  output logic retry_dual_out, // Busy uses dual phase retry.
  output logic arb_request_out, // Transmitter arbitrates for the bus.
  output logic reserved_sel_out // Selector holds a reserved code.
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic node_address_valid_q; // Node address valid control.
  logic self_identify_capture_q; // Self-identify capture control.
  busy_sel_t busy_response_select_q; // Busy-response selector.
  logic transmit_permit_q; // Transmit permit control.
  logic ack_q; // Bus answer cycle.
  sid_state_e sid_q; // Self-ID merge state.
  logic force_busy; // Decoded always-busy.
  logic force_single; // Decoded single phase retry.
  logic hit; // Request targets the register.
  logic wr_upper; // Write touching the upper byte.
  logic node_ok; // Node packet would be accepted.
  logic done_pend_q; // Self-ID completed, node identifier refresh still awaited.
  logic valid_set; // Hardware sets node address valid this cycle.
  localparam logic [31:0] glc_reset_word = `LCU_GLC_RESET; // Register value after reset.

  // Returns the register word from its fields.
  function automatic logic [31:0] pack_word(input logic v, input logic c,
                                           input busy_sel_t b, input logic t);
    pack_word = {v, c, b, t, `LCU_LOWER_RESET};
  endfunction : pack_word

  // --------------------------------------------------------------------------
  // Avalon-MM slave
  // --------------------------------------------------------------------------
  assign hit = (avs_address_in == `LCU_GLC_OFFSET);
  assign wr_upper = avs_write_in && ack_q && hit && avs_byteenable_in[`LCU_BYTE_UPPER];

  // Stalls the first cycle of each request; the answer comes in the second.
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;

  // Pulses the answer cycle once per request.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read_in || avs_write_in) && !ack_q;
  end

  // Captures read data; unmapped addresses read as zero.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && !ack_q && hit)
      avs_readdata_out <= pack_word(node_address_valid_q, self_identify_capture_q,
                                    busy_response_select_q, transmit_permit_q);
    else if (avs_read_in && !ack_q)
      avs_readdata_out <= 32'h0000_0000;
  end

  // --------------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------------
  // Remembers a finished self-ID until the node identifier refresh that follows it.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      done_pend_q <= 1'b0;
    else if (node_id_refresh_in)
      done_pend_q <= 1'b0; // Refresh consumes the pending completion.
    else if (selfid_done_in)
      done_pend_q <= 1'b1;
  end

  // Both events may fall in one cycle, or the refresh may come later.
  assign valid_set = node_id_refresh_in && (selfid_done_in || done_pend_q);

  // Node address valid; the hardware set wins over a software clear.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      node_address_valid_q <= glc_reset_word[`LCU_BIT_VALID];
    else if (valid_set)
      node_address_valid_q <= 1'b1;
    else if (wr_upper)
      node_address_valid_q <= avs_writedata_in[`LCU_BIT_VALID];
  end

  // Capture, selector and transmit permit are plain software fields.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      self_identify_capture_q <= glc_reset_word[`LCU_BIT_CAPTURE];
      busy_response_select_q <= glc_reset_word[`LCU_BUSY_HI:`LCU_BUSY_LO];
      transmit_permit_q <= glc_reset_word[`LCU_BIT_PERMIT];
    end
    else if (wr_upper)
    begin
      self_identify_capture_q <= avs_writedata_in[`LCU_BIT_CAPTURE];
      busy_response_select_q <= avs_writedata_in[`LCU_BUSY_HI:`LCU_BUSY_LO];
      transmit_permit_q <= avs_writedata_in[`LCU_BIT_PERMIT];
    end
  end

  // --------------------------------------------------------------------------
  // Busy decode
  // --------------------------------------------------------------------------
  busy_response_decode u_decode
  (
    .sel_in(busy_response_select_q),
    .force_busy_out(force_busy),
    .force_single_out(force_single),
    .reserved_out(reserved_sel_out)
  );

  // --------------------------------------------------------------------------
  // Self-ID merge
  // --------------------------------------------------------------------------
  // Opens a merged packet at the first captured self-ID and closes it at completion.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sid_q <= SID_IDLE;
    else
    begin
      case (sid_q)
        SID_IDLE:
          if (pkt_strobe_in && pkt_selfid_in && self_identify_capture_q)
            sid_q <= SID_OPEN;
        SID_OPEN:
          if (selfid_done_in)
            sid_q <= SID_IDLE;
        default: sid_q <= SID_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Packet decisions
  // --------------------------------------------------------------------------
  assign node_ok = pkt_to_node_in && node_address_valid_q && !link_busy_in && !force_busy;

  // Registers one decision per packet strobe.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      decision_valid_out <= 1'b0;
      accept_out <= 1'b0;
      enqueue_out <= 1'b0;
      selfid_start_out <= 1'b0;
      ack_busy_out <= 1'b0;
      retry_dual_out <= 1'b0;
    end
    else
    begin
      decision_valid_out <= pkt_strobe_in;
      accept_out <= pkt_strobe_in && node_ok;
      enqueue_out <= pkt_strobe_in && (node_ok || (self_identify_capture_q &&
                     (pkt_selfid_in || pkt_phycfg_in)));
      selfid_start_out <= pkt_strobe_in && pkt_selfid_in && self_identify_capture_q &&
                          (sid_q == SID_IDLE);
      ack_busy_out <= pkt_strobe_in && pkt_to_node_in && (force_busy || link_busy_in);
      retry_dual_out <= pkt_strobe_in && pkt_wants_dual_in && !force_single;
    end
  end

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  // Arbitration request follows the permit and a pending packet.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      arb_request_out <= 1'b0;
    else
      arb_request_out <= transmit_permit_q && tx_pending_in;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_accept_gate;
    pkt_strobe_in && pkt_to_node_in && !node_address_valid_q |=> !accept_out;
  endproperty
  a_accept_gate: assert property (p_accept_gate) else $error("accept without valid");

  property p_accept_ok;
    pkt_strobe_in && node_ok |=> accept_out && enqueue_out && !ack_busy_out;
  endproperty
  a_accept_ok: assert property (p_accept_ok) else $error("node packet dropped");

  property p_valid_set;
    selfid_done_in && node_id_refresh_in |=> node_address_valid_q ##1
      (node_address_valid_q || $past(wr_upper));
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("valid not set");

  property p_selfid_queue;
    pkt_strobe_in && pkt_selfid_in && self_identify_capture_q && sid_q == SID_IDLE
      |=> enqueue_out && selfid_start_out;
  endproperty
  a_selfid_queue: assert property (p_selfid_queue) else $error("self-ID not queued");

  property p_phycfg_off;
    pkt_strobe_in && pkt_phycfg_in && !self_identify_capture_q && !pkt_to_node_in
      |=> !enqueue_out;
  endproperty
  a_phycfg_off: assert property (p_phycfg_off) else $error("PHY config queued");

  property p_follow;
    pkt_strobe_in && busy_response_select_q == 3'h0 |=> retry_dual_out == $past(pkt_wants_dual_in);
  endproperty
  a_follow: assert property (p_follow) else $error("retry not followed");

  property p_single;
    pkt_strobe_in && busy_response_select_q == 3'h3 |=> !retry_dual_out;
  endproperty
  a_single: assert property (p_single) else $error("dual retry under single");

  property p_all_busy;
    pkt_strobe_in && pkt_to_node_in && busy_response_select_q == 3'h4
      |=> ack_busy_out && !accept_out && retry_dual_out == $past(pkt_wants_dual_in);
  endproperty
  a_all_busy: assert property (p_all_busy) else $error("busy ack missing");

  property p_all_single;
    pkt_strobe_in && pkt_to_node_in && busy_response_select_q == 3'h7
      |=> ack_busy_out && !retry_dual_out;
  endproperty
  a_all_single: assert property (p_all_single) else $error("busy single missing");

  property p_permit;
    !transmit_permit_q ##1 !transmit_permit_q |-> !arb_request_out;
  endproperty
  a_permit: assert property (p_permit) else $error("arbitration without permit");

  property p_valid_late;
    done_pend_q && node_id_refresh_in |=> node_address_valid_q;
  endproperty
  a_valid_late: assert property (p_valid_late) else $error("late refresh lost");

  property p_merge_once;
    pkt_strobe_in && sid_q == SID_OPEN |=> !selfid_start_out;
  endproperty
  a_merge_once: assert property (p_merge_once) else $error("second merged start");

  property p_phycfg_on;
    pkt_strobe_in && pkt_phycfg_in && self_identify_capture_q |=> enqueue_out;
  endproperty
  a_phycfg_on: assert property (p_phycfg_on) else $error("PHY config not queued");

  property p_permit_on;
    transmit_permit_q && tx_pending_in |=> arb_request_out;
  endproperty
  a_permit_on: assert property (p_permit_on) else $error("arbitration missing");

  c_late: cover property (done_pend_q && node_id_refresh_in);
  c_write: cover property (wr_upper);
  c_merge: cover property (selfid_start_out ##[1:20] enqueue_out);
  c_busy: cover property (ack_busy_out);
  c_arb: cover property (arb_request_out);
endmodule : link_control_upper_bits

// File: hdl/link_ctl_params.svh
/*
  Offsets, field positions, reset values and selector codes for the upper link control bits.
  Assumes it is included by bare name from the package only; the design modules use its macros without including it.
*/
`ifndef LINK_CTL_PARAMS_SVH
`define LINK_CTL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define LCU_ADDR_W 8
`define LCU_GLC_OFFSET 8'h04
`define LCU_GLC_RESET 32'h4600_0002
`define LCU_LOWER_RESET 26'h200_0002

// ----------------------------------------------------------------------------
// Field positions inside the register
// ----------------------------------------------------------------------------
`define LCU_BIT_VALID 31
`define LCU_BIT_CAPTURE 30
`define LCU_BUSY_HI 29
`define LCU_BUSY_LO 27
`define LCU_BIT_PERMIT 26
`define LCU_BYTE_UPPER 3

// ----------------------------------------------------------------------------
// Busy-response selector codes
// ----------------------------------------------------------------------------
`define LCU_BUSY_FOLLOW 3'h0
`define LCU_BUSY_SINGLE 3'h3
`define LCU_BUSY_ALL_FOLLOW 3'h4
`define LCU_BUSY_ALL_SINGLE 3'h7

`endif

// File: hdl/link_ctl_pkg.sv
/*
  Types shared by the upper link control bits.
  Assumes link_ctl_params.svh is on the include path.
*/
package link_ctl_pkg;
  `include "link_ctl_params.svh"

  // Self-identify capture progress, Gray coded along idle to open.
  typedef enum logic [1:0]
  {
    SID_IDLE = 2'b00,
    SID_OPEN = 2'b01
  } sid_state_e;

  // Selector width.
  typedef logic [2:0] busy_sel_t;
endpackage : link_ctl_pkg

// File: hdl/busy_response_decode.sv
/*
  Decodes the busy-response selector into the acknowledge and retry controls.
  Assumes a selector that comes straight from a register on the same clock.
*/
`timescale 1ns/100ps
module busy_response_decode
  import link_ctl_pkg::*;
(
  input wire busy_sel_t sel_in, // Busy-response selector.
  output logic force_busy_out, // Every packet addressed to the node gets a busy acknowledge.
  output logic force_single_out, // Single phase retry regardless of the packet.
  output logic reserved_out // Code with no defined behaviour.
);

  // Maps each code; reserved codes fall back to the packet's own protocol.
  always_comb
  begin
    force_busy_out = 1'b0;
    force_single_out = 1'b0;
    reserved_out = 1'b0;
    case (sel_in)
      `LCU_BUSY_FOLLOW: force_single_out = 1'b0;
      `LCU_BUSY_SINGLE: force_single_out = 1'b1;
      `LCU_BUSY_ALL_FOLLOW: force_busy_out = 1'b1;
      `LCU_BUSY_ALL_SINGLE:
      begin
        force_busy_out = 1'b1;
        force_single_out = 1'b1;
      end
      default: reserved_out = 1'b1;
    endcase
  end
endmodule : busy_response_decode

// File: bench/phy_pkt_model.sv
/*
  Behavioural far-side model: hands received packet headers to the link one at a time.
  Assumes the bench clock and a caller that waits for each send to return.
*/
`timescale 1ns/100ps
module phy_pkt_model
(
  input wire logic clk_in, // Bench clock.
  output logic strobe_out, // One packet header per pulse.
  output logic [4:0] hdr_out // To-node, self-ID, PHY config, wants dual, link busy.
);
  initial
  begin
    strobe_out = 1'b0;
    hdr_out = 5'h00;
  end

  // One-cycle header pulse; the qualifiers are inverted afterwards so no stale value lingers.
  task automatic send(input logic [4:0] f);
    @(posedge clk_in);
    strobe_out <= 1'b1;
    hdr_out <= f;
    @(posedge clk_in);
    strobe_out <= 1'b0;
    hdr_out <= ~f;
  endtask : send
endmodule : phy_pkt_model

// File: bench/link_control_upper_bits_tb.sv
/*
  Self-checking bench for the upper link control bits: bus tasks, packets and a queue monitor.
  Assumes the design package, the design modules and phy_pkt_model are compiled first.
*/
`timescale 1ns/100ps
module link_control_upper_bits_tb
  import link_ctl_pkg::*;
;
  logic ref_clk_in, arst_n_in, avs_read_in, avs_write_in, tx_pending_in;
  logic selfid_done_in, node_id_refresh_in, avs_waitrequest_out, decision_valid_out;
  logic accept_out, enqueue_out, ack_busy_out, retry_dual_out, arb_request_out;
  logic reserved_sel_out, pkt_strobe, selfid_start_out, merged;
  logic [7:0] avs_address_in, rnd;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  logic [4:0] pkt_hdr;
  logic [5:0] up;
  logic [31:0] rq[$], pq[$];
  int bad_count, num_checks;

  link_control_upper_bits uut
  (
    .ref_clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .selfid_done_in, .node_id_refresh_in, .pkt_strobe_in(pkt_strobe),
    .pkt_to_node_in(pkt_hdr[4]), .pkt_selfid_in(pkt_hdr[3]), .pkt_phycfg_in(pkt_hdr[2]),
    .pkt_wants_dual_in(pkt_hdr[1]), .link_busy_in(pkt_hdr[0]), .tx_pending_in,
    .decision_valid_out, .accept_out, .enqueue_out, .selfid_start_out, .ack_busy_out,
    .retry_dual_out, .arb_request_out, .reserved_sel_out
  );

  phy_pkt_model phy
  (
    .clk_in(ref_clk_in),
    .strobe_out(pkt_strobe),
    .hdr_out(pkt_hdr)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // Pseudo-random source, seeded at 91.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Expected {accept, enqueue, busy ack, dual retry, arbitration, merge start} for header f.
  // The flag op says that a merged self-ID packet is already open.
  function automatic logic [31:0] exp_pkt(input logic [4:0] f, input logic [5:0] u,
                                          input logic tx, input logic op);
    logic fb, fs, ac, st;
    fb = (u[3:1] == 3'h4) || (u[3:1] == 3'h7);
    fs = (u[3:1] == 3'h3) || (u[3:1] == 3'h7);
    ac = f[4] & u[5] & !f[0] & !fb;
    st = f[3] & u[4] & !op;
    return {26'h000_0000, ac, ac | (u[4] & (f[3] | f[2])), f[4] & (fb | f[0]), f[1] & !fs,
            u[0] & tx, st};
  endfunction : exp_pkt

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp

  // One bus cycle; the request is held until a rising edge samples waitrequest low.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge ref_clk_in);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    acc(1'b0, a, 32'h0000_0000, 4'hf);
  endtask : rd

  // Monitor: takes the oldest note whenever a read completes or a decision appears.
  always @(negedge ref_clk_in)
  begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
      cmp("readdata", (rq.size() != 0) ? rq.pop_front() : 'x, avs_readdata_out);
    if (decision_valid_out === 1'b1)
      cmp("decision", (pq.size() != 0) ? pq.pop_front() : 'x, {26'h000_0000, accept_out,
          enqueue_out, ack_busy_out, retry_dual_out, arb_request_out,
          selfid_start_out});
  end

  task automatic give_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Watchdog: the whole run needs well under 5000 cycles.
  initial
  begin
    #100000;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    {arst_n_in, avs_read_in, avs_write_in, selfid_done_in, node_id_refresh_in} = 5'h00;
    {tx_pending_in, avs_address_in, avs_writedata_in, avs_byteenable_in} = 45'h0;
    rnd = 8'h5b;
    merged = 1'b0;
    repeat (6) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    // Reset value, unmapped place and a write without the upper byte lane.
    rd(8'h04, 32'h4600_0002);
    rd(8'h08, 32'h0000_0000);
    acc(1'b1, 8'h04, 32'hffff_ffff, 4'h7);
    rd(8'h04, 32'h4600_0002);
    // Each defined selector code four times, twice with address valid off and twice on, then random packets.
    // Software keeps to the defined codes 000, 011, 100 and 111 only.
    for (int c = 0; c < 8; c++)
      for (int v = 0; v < 2; v++)
      begin
        rnd = lfsr(rnd);
        up = {v[0], rnd[0], c[1], {2{c[0]}}, rnd[1]};
        acc(1'b1, 8'h04, {up, {3{rnd}}, rnd[1:0]}, 4'hf);
        tx_pending_in <= rnd[2];
        rd(8'h04, {up, 26'h200_0002});
        cmp("reserved", 32'h0000_0000, {31'h0, reserved_sel_out});
        repeat (6)
        begin
          rnd = lfsr(rnd);
          pq.push_back(exp_pkt(rnd[4:0], up, tx_pending_in, merged));
          merged = merged | (rnd[3] & up[4]);
          phy.send(rnd[4:0]);
        end
      end
    // Self-identification done, then a fresh node identifier, sets address valid.
    acc(1'b1, 8'h04, 32'h0000_0000, 4'hf);
    @(posedge ref_clk_in);
    selfid_done_in <= 1'b1;
    @(posedge ref_clk_in);
    selfid_done_in <= 1'b0;
    node_id_refresh_in <= 1'b1;
    @(posedge ref_clk_in);
    node_id_refresh_in <= 1'b0;
    rd(8'h04, 32'h8200_0002);
    // A reset in mid-run brings every field back to its reset value.
    arst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    rd(8'h04, 32'h4600_0002);
    repeat (4) @(posedge ref_clk_in);
    give_verdict();
  end
endmodule : link_control_upper_bits_tb
